// ---- rtl/pll_sync_config_regs.vh ----
// register offsets, field positions, reset values for the pll and sync config bank
// assumes 8-bit registers on a byte-addressed serial control port
`ifndef PLL_SYNC_CONFIG_REGS_VH
`define PLL_SYNC_CONFIG_REGS_VH
`define ADDR_W                    7
`define OFS_PLL_ENABLE_BAND_CTRL  7'h0a
`define OFS_PLL_LOOP_PUMP_CTRL    7'h0c
`define OFS_PLL_DIVIDER_CTRL      7'h0d
`define OFS_PLL_LOCK_VOLTAGE_STAT 7'h0e
`define OFS_PLL_BAND_STAT         7'h0f
`define OFS_SYNC_MODE_CTRL        7'h10
`define RST_PLL_ENABLE_BAND_CTRL  8'h40
`define RST_PLL_LOOP_PUMP_CTRL    8'hd1
`define RST_PLL_DIVIDER_CTRL      8'hd9
`define RST_SYNC_MODE_CTRL        8'h48
`define MASK_PLL_ENABLE_BAND_CTRL 8'hff
`define MASK_PLL_LOOP_PUMP_CTRL   8'hff
`define MASK_PLL_DIVIDER_CTRL     8'hdf
`define MASK_SYNC_MODE_CTRL       8'hcf
`define BIT_PLL_ENABLE            7
`define BIT_MANUAL_BAND           6
`define BIT_XPOINT_EN             4
`define BIT_LOCK                  7
`define BIT_SYNC_ENABLE           7
`define BIT_SYNC_DATA_RATE        6
`define BIT_SYNC_RISING           3
`define AVG_CODE_MAX              3'h5
`endif

// ---- rtl/clock_ratio_divider.v ----
// one-cycle enable pulse every 2**(code+1) clocks; a divider used for the controller clock ratio
// assumes code is a quasi-static register value on the same clock
`timescale 1ns/1ps
module clock_ratio_divider #(
  parameter W = 5
) (
  input  wire       ref_clk_i,
  input  wire       reset_i,
  input  wire       run_i,
  input  wire [1:0] code_i,
  output reg        tick_o
);
  reg [W-1:0] cnt_ff;
  // shift amount is three bits wide so that code 3 gives 16 and does not wrap to 1
  wire [W-1:0] last = (({{(W-1){1'b0}},1'b1}) << ({1'b0, code_i} + 3'd1)) - {{(W-1){1'b0}},1'b1};
  // count to ratio-1 then pulse
  always @(posedge ref_clk_i) begin
    if (reset_i || !run_i) begin
      cnt_ff <= {W{1'b0}};
      tick_o <= 1'b0;
    end else if (cnt_ff >= last) begin
      cnt_ff <= {W{1'b0}};
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + {{(W-1){1'b0}},1'b1};
      tick_o <= 1'b0;
    end
  end
endmodule

// ---- rtl/pll_sync_config.v ----
// pll and multichip sync configuration/status register bank on the serial control port
// assumes a port decoder gives one-cycle write/read strobes with an address; status inputs
// from the analog pll and sync edge input are asynchronous and are synchronised here
// Operation
// RULE_01: pll enable bit 7 of first pll control turns on multiplier; resets zero.
// RULE_02: manual-band bit, reset one, makes device use software band.
// RULE_03: six-bit manual band field in first pll control, reset zero.
// RULE_04: loop bandwidth bits 7:5 of second control, codes 000..110, reset 110.
// RULE_05: five-bit charge pump current, 00000 lowest to 11111 highest, reset 10001.
// RULE_06: controller clock divider bits 7:6 gives ratio 2,4,8,16; reset 3.
// RULE_07: software keeps controller clock below 80 MHz.
// RULE_08: bit 4 of third control enables cross-point controller, reset one.
// RULE_09: oscillator divider bits 3:2 gives ratio 1,2,4; reset 10.
// RULE_10: loop divider bits 1:0 gives ratio 2,4,8,16; reset 01.
// RULE_11: status bit 7 reads high while pll tracks reference, read only.
// RULE_12: status low four bits return oscillator control voltage code.
// RULE_13: second status low six bits return band in use.
// RULE_14: sync control bit 7 enables synchronisation logic, reset zero.
// RULE_15: bit 6 picks fifo-reset rate (0) or data rate (1), reset one.
// RULE_16: bit 3 picks falling (0) or rising (1) sync edge, reset one.
// RULE_17: three-bit averaging field gives 2**code samples up to 32, reset zero.
// RULE_18: unlisted bits read zero, ignore writes; status ignores writes.
`timescale 1ns/1ps
`include "pll_sync_config_regs.vh"
module pll_sync_config (
  input  wire                 ref_clk_i,
  input  wire                 reset_i,
  input  wire                 wr_en_i,
  input  wire                 rd_en_i,
  input  wire [`ADDR_W-1:0]   addr_i,
  input  wire [7:0]           wr_data_i,
  output reg  [7:0]           rd_data_o,
  output reg                  rd_valid_o,
  input  wire                 pll_lock_i,
  input  wire [3:0]           vco_voltage_i,
  input  wire [5:0]           auto_band_i,
  input  wire                 sync_in_i,
  output wire                 pll_enable_o,
  output wire                 manual_band_o,
  output wire [5:0]           band_select_o,
  output wire [2:0]           loop_bandwidth_o,
  output wire [4:0]           charge_pump_o,
  output wire [1:0]           controller_clock_divider_o,
  output wire                 xpoint_enable_o,
  output wire [1:0]           oscillator_output_divider_o,
  output wire [1:0]           loop_feedback_divider_o,
  output wire                 controller_clock_tick_o,
  output wire                 sync_enable_o,
  output wire                 sync_data_rate_o,
  output reg                  sync_trigger_o,
  output wire [5:0]           sync_samples_o
);
  reg [7:0] ctrl1_ff;
  reg [7:0] ctrl2_ff;
  reg [7:0] ctrl3_ff;
  reg [7:0] sync1_ff;
  reg       lock_s1_ff;
  reg       lock_ff;
  reg [3:0] volt_s1_ff;
  reg [3:0] volt_s2_ff;
  reg [3:0] volt_ff;
  reg [5:0] band_s2_ff;
  reg [5:0] band_s1_ff;
  reg [5:0] band_ff;
  reg       sync_s1_ff;
  reg       sync_s2_ff;
  reg       sync_prev_ff;
  reg [7:0] nxt_rd_data;
  wire [5:0] band_in_use;

  // writable registers; masks clear unlisted bits, status offsets not decoded for writes
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl1_ff <= `RST_PLL_ENABLE_BAND_CTRL; // [RULE_01] [RULE_02] [RULE_03]
      ctrl2_ff <= `RST_PLL_LOOP_PUMP_CTRL;   // [RULE_04] [RULE_05]
      ctrl3_ff <= `RST_PLL_DIVIDER_CTRL;     // [RULE_06] [RULE_08] [RULE_09] [RULE_10]
      sync1_ff <= `RST_SYNC_MODE_CTRL;       // [RULE_14] [RULE_15] [RULE_16] [RULE_17]
    end else if (wr_en_i) begin
      case (addr_i)
        `OFS_PLL_ENABLE_BAND_CTRL: ctrl1_ff <= wr_data_i & `MASK_PLL_ENABLE_BAND_CTRL;
        `OFS_PLL_LOOP_PUMP_CTRL:   ctrl2_ff <= wr_data_i & `MASK_PLL_LOOP_PUMP_CTRL;
        `OFS_PLL_DIVIDER_CTRL:     ctrl3_ff <= wr_data_i & `MASK_PLL_DIVIDER_CTRL; // [RULE_18]
        `OFS_SYNC_MODE_CTRL:       sync1_ff <= wr_data_i & `MASK_SYNC_MODE_CTRL;   // [RULE_18]
        default: ;                                                                 // [RULE_18]
      endcase
    end
  end

  // two-flop synchronisers for analog status and the sync pin
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      lock_s1_ff   <= 1'b0;
      lock_ff      <= 1'b0;
      volt_s1_ff   <= 4'h0;
      volt_s2_ff   <= 4'h0;
      volt_ff      <= 4'h0;
      band_s1_ff   <= 6'h00;
      band_s2_ff   <= 6'h00;
      band_ff      <= 6'h00;
      sync_s1_ff   <= 1'b0;
      sync_s2_ff   <= 1'b0;
      sync_prev_ff <= 1'b0;
    end else begin
      lock_s1_ff   <= pll_lock_i;
      lock_ff      <= lock_s1_ff;
      // multi-bit words: take a value only once two synced samples agree,
      // so a word caught mid-change never reaches the read mux
      volt_s1_ff   <= vco_voltage_i;
      volt_s2_ff   <= volt_s1_ff;
      if (volt_s2_ff == volt_s1_ff) begin
        volt_ff <= volt_s2_ff;
      end
      band_s1_ff   <= auto_band_i;
      band_s2_ff   <= band_s1_ff;
      if (band_s2_ff == band_s1_ff) begin
        band_ff <= band_s2_ff;
      end
      sync_s1_ff   <= sync_in_i;
      sync_s2_ff   <= sync_s1_ff;
      sync_prev_ff <= sync_s2_ff;
    end
  end

  // band in use: software band in manual mode, else the calibrated one
  assign band_in_use = ctrl1_ff[`BIT_MANUAL_BAND] ? ctrl1_ff[5:0] : band_ff; // [RULE_02]

  // read mux; lock only meaningful while pll runs
  always @* begin
    nxt_rd_data = 8'h00; // [RULE_18]
    case (addr_i)
      `OFS_PLL_ENABLE_BAND_CTRL:  nxt_rd_data = ctrl1_ff;
      `OFS_PLL_LOOP_PUMP_CTRL:    nxt_rd_data = ctrl2_ff;
      `OFS_PLL_DIVIDER_CTRL:      nxt_rd_data = ctrl3_ff;
      `OFS_PLL_LOCK_VOLTAGE_STAT: nxt_rd_data = {lock_ff & ctrl1_ff[`BIT_PLL_ENABLE], 3'h0,
                                                 volt_ff};          // [RULE_11] [RULE_12]
      `OFS_PLL_BAND_STAT:         nxt_rd_data = {2'h0, band_in_use}; // [RULE_13]
      `OFS_SYNC_MODE_CTRL:        nxt_rd_data = sync1_ff;
      default:                    nxt_rd_data = 8'h00;
    endcase
  end

  // registered read data, one cycle after the strobe
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rd_data_o <= nxt_rd_data;
      end
    end
  end

  // sync trigger on the selected edge while enabled
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      sync_trigger_o <= 1'b0;
    end else begin
      sync_trigger_o <= sync1_ff[`BIT_SYNC_ENABLE] &                           // [RULE_14]
                        (sync1_ff[`BIT_SYNC_RISING] ? (sync_s2_ff & ~sync_prev_ff)
                                                    : (~sync_s2_ff & sync_prev_ff)); // [RULE_16]
    end
  end

  // field outputs
  assign pll_enable_o                = ctrl1_ff[`BIT_PLL_ENABLE];   // [RULE_01]
  assign manual_band_o               = ctrl1_ff[`BIT_MANUAL_BAND];  // [RULE_02]
  assign band_select_o               = ctrl1_ff[5:0];               // [RULE_03]
  assign loop_bandwidth_o            = ctrl2_ff[7:5];               // [RULE_04]
  assign charge_pump_o               = ctrl2_ff[4:0];               // [RULE_05]
  assign controller_clock_divider_o  = ctrl3_ff[7:6];               // [RULE_06]
  assign xpoint_enable_o             = ctrl3_ff[`BIT_XPOINT_EN];    // [RULE_08]
  assign oscillator_output_divider_o = ctrl3_ff[3:2];               // [RULE_09]
  assign loop_feedback_divider_o     = ctrl3_ff[1:0];               // [RULE_10]
  assign sync_enable_o               = sync1_ff[`BIT_SYNC_ENABLE];  // [RULE_14]
  assign sync_data_rate_o            = sync1_ff[`BIT_SYNC_DATA_RATE]; // [RULE_15]
  // averaging count 2**code, codes above 5 clamp to 32
  assign sync_samples_o = (sync1_ff[2:0] > `AVG_CODE_MAX) ? 6'h20
                          : (6'h01 << sync1_ff[2:0]);               // [RULE_17]

  // controller clock enable: ratio 2,4,8,16 of the sample clock (here ref_clk_i)
  clock_ratio_divider #(
    .W (5)
  ) u_ctrl_div (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .run_i     (ctrl1_ff[`BIT_PLL_ENABLE]),
    .code_i    (ctrl3_ff[7:6]),
    .tick_o    (controller_clock_tick_o)                            // [RULE_06]
  );
endmodule

// ---- tb/pll_sync_config_assertions.sv ----
// concurrent checks on the pll and sync register bank ports
// assumes it is bound onto pll_sync_config; one clock domain
`timescale 1ns/1ps
`include "pll_sync_config_regs.vh"
module pll_sync_config_checker (
  input wire ref_clk_i, input wire reset_i, input wire wr_en_i, input wire rd_en_i,
  input wire [`ADDR_W-1:0] addr_i, input wire [7:0] wr_data_i, input wire [7:0] rd_data_o,
  input wire rd_valid_o, input wire pll_enable_o, input wire sync_enable_o,
  input wire sync_trigger_o, input wire [5:0] sync_samples_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // write strobe aimed at the sync mode register
  wire wr_sync = wr_en_i && addr_i == `OFS_SYNC_MODE_CTRL;
  rd_answer_a: assert property (rd_en_i |=> rd_valid_o) else $error("read unanswered");
  rd_quiet_a: assert property (!rd_en_i |=> !rd_valid_o && $stable(rd_data_o))
    else $error("read data moved");
  pll_enable_a: assert property (wr_en_i && addr_i == `OFS_PLL_ENABLE_BAND_CTRL
    |=> pll_enable_o == $past(wr_data_i[7])) else $error("pll enable wrong");
  unmapped_zero_a: assert property (rd_en_i && addr_i == 7'h7f |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  divider_gap_a: assert property (rd_en_i && addr_i == `OFS_PLL_DIVIDER_CTRL
    |=> !rd_data_o[5]) else $error("unused divider bit set");
  sync_enable_a: assert property (wr_sync |=> sync_enable_o == $past(wr_data_i[7]))
    else $error("sync enable wrong");
  avg_count_a: assert property (wr_sync |=> sync_samples_o ==
    (($past(wr_data_i[2:0]) > 3'h5) ? 6'h20 : (6'h01 << $past(wr_data_i[2:0]))))
    else $error("sample count wrong");
  trig_gate_a: assert property (sync_trigger_o |-> $past(sync_enable_o)) else $error("trigger ungated");
endmodule
bind pll_sync_config pll_sync_config_checker pll_sync_config_checker_i (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .pll_enable_o(pll_enable_o), .sync_enable_o(sync_enable_o),
  .sync_trigger_o(sync_trigger_o), .sync_samples_o(sync_samples_o));

// ---- tb/pll_sync_config_test.sv ----
// self-checking bench for the pll and sync register bank
// assumes the bank's strobe port and status pins are driven here directly
`timescale 1ns/1ps
module pll_sync_config_test;
  reg ref_clk_i = 1'b0, reset_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
  reg pll_lock_i = 1'b0, sync_in_i = 1'b0;
  reg [6:0] addr_i = 7'h00;
  reg [7:0] wr_data_i = 8'h00;
  reg [3:0] vco_voltage_i = 4'h0;
  reg [5:0] auto_band_i = 6'h00;
  wire [7:0] rd_data_o;
  wire rd_valid_o, pll_enable_o, manual_band_o, xpoint_o, tick_o, sync_en_o, sync_rate_o, trig_o;
  wire [5:0] band_o, samples_o;
  wire [2:0] bw_o;
  wire [4:0] pump_o;
  wire [1:0] ccd_o, odiv_o, ldiv_o;
  integer num_errors = 0, cmp_count = 0, i, n, m;
  always #4 ref_clk_i = ~ref_clk_i;
  pll_sync_config pll_sync_config_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .pll_lock_i(pll_lock_i),
    .vco_voltage_i(vco_voltage_i), .auto_band_i(auto_band_i), .sync_in_i(sync_in_i),
    .pll_enable_o(pll_enable_o), .manual_band_o(manual_band_o), .band_select_o(band_o),
    .loop_bandwidth_o(bw_o), .charge_pump_o(pump_o), .controller_clock_divider_o(ccd_o),
    .xpoint_enable_o(xpoint_o), .oscillator_output_divider_o(odiv_o),
    .loop_feedback_divider_o(ldiv_o), .controller_clock_tick_o(tick_o),
    .sync_enable_o(sync_en_o), .sync_data_rate_o(sync_rate_o), .sync_trigger_o(trig_o),
    .sync_samples_o(samples_o));
  // compare one value and count it
  task chk(input [31:0] what, input [7:0] seen, input [7:0] exp); begin
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  end endtask
  // one-cycle write strobe
  task wr(input [6:0] a, input [7:0] d); begin
    @(negedge ref_clk_i);
    wr_en_i = 1'b1;
    addr_i = a;
    wr_data_i = d;
    @(negedge ref_clk_i);
    wr_en_i = 1'b0;
  end endtask
  // one-cycle read strobe, answer checked the cycle after
  task rd(input [6:0] a, input [7:0] exp); begin
    @(negedge ref_clk_i);
    rd_en_i = 1'b1;
    addr_i = a;
    @(negedge ref_clk_i);
    rd_en_i = 1'b0;
    chk("vld", rd_valid_o, 8'h01);
    chk("rd", rd_data_o, exp);
  end endtask
  // count tick and trigger pulses over c cycles
  task count(input integer c); begin
    n = 0;
    m = 0;
    repeat (c) begin
      @(negedge ref_clk_i);
      n = n + tick_o;
      m = m + trig_o;
    end
  end endtask
  // move the sync pin and expect a number of triggers
  task edge_t(input v, input [7:0] exp); begin
    sync_in_i = v;
    count(6);
    chk("trg", m, exp);
  end endtask
  task summarize; begin
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end endtask
  // watchdog well beyond the few hundred cycles the tests take
  initial begin
    #100000;
    num_errors = num_errors + 1;
    summarize;
  end
  initial begin
    repeat (5) @(negedge ref_clk_i);
    reset_i = 1'b0;
    rd(7'h0a, 8'h40);
    rd(7'h0c, 8'hd1);
    rd(7'h0d, 8'hd9);
    rd(7'h10, 8'h48);
    rd(7'h0f, 8'h00);
    chk("man", {manual_band_o, band_o, pll_enable_o}, 8'h80);
    chk("lp", {bw_o, pump_o}, 8'hd1);
    chk("div", {ccd_o, xpoint_o, odiv_o, ldiv_o}, 8'h79);
    chk("syn", {sync_en_o, sync_rate_o, samples_o}, 8'h41);
    $display("reset values test done");
    wr(7'h0a, 8'hff);
    rd(7'h0a, 8'hff);
    chk("man", {manual_band_o, band_o, pll_enable_o}, 8'hff);
    wr(7'h0c, 8'h00);
    chk("lp", {bw_o, pump_o}, 8'h00);
    wr(7'h0d, 8'hff);
    rd(7'h0d, 8'hdf);
    chk("div", {ccd_o, xpoint_o, odiv_o, ldiv_o}, 8'h7f);
    wr(7'h10, 8'hff);
    rd(7'h10, 8'hcf);
    chk("syn", {sync_en_o, sync_rate_o, samples_o}, 8'he0);
    wr(7'h0e, 8'hff);
    rd(7'h0e, 8'h00);
    wr(7'h0f, 8'h00);
    rd(7'h0f, 8'h3f);
    wr(7'h7f, 8'hff);
    rd(7'h7f, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      wr(7'h10, 8'h80 | i);
      chk("avg", samples_o, 8'h01 << i);
    end
    $display("write test done");
    pll_lock_i = 1'b1;
    vco_voltage_i = 4'ha;
    auto_band_i = 6'h2a;
    count(4);
    rd(7'h0e, 8'h8a);
    wr(7'h0a, 8'h3f);
    rd(7'h0f, 8'h2a);
    rd(7'h0e, 8'h0a);
    wr(7'h0a, 8'h80);
    for (i = 0; i < 4; i = i + 1) begin
      wr(7'h0d, i << 6); // 125 MHz / 2 at most stays below 80 MHz
      count(32);
      count(64);
      chk("tck", n, 64 >> (i + 1));
    end
    wr(7'h0a, 8'h00);
    count(64);
    chk("tck", n, 8'h00);
    $display("status and divider test done");
    wr(7'h10, 8'h88);
    edge_t(1'b1, 8'h01);
    edge_t(1'b0, 8'h00);
    wr(7'h10, 8'h80);
    edge_t(1'b1, 8'h00);
    edge_t(1'b0, 8'h01);
    wr(7'h10, 8'h08);
    edge_t(1'b1, 8'h00);
    $display("sync edge test done");
    summarize;
  end
endmodule
